//--- verilog/fsb_bank.sv
//Operation
// - Input byte bit 7 latches on input over-voltage fault, else reads 0.
// - Input byte bit 4 latches on input under-voltage fault, else reads 0.
// - Input byte bit 2 latches on input over-current fault, else reads 0.
// - Input byte bit 1 latches on input over-current warning, else reads 0.
// - Unsupported and reserved bits of every byte always read zero.
// - Temperature byte bit 7 latches on over-temperature fault.
// - Temperature byte bit 6 latches on over-temperature warning.
// - Temperature command returns one byte, default 0x00.
// - Communication command returns one byte, default 0x00.
// - Communication bit 7 latches on invalid or unsupported command.
// - Communication bit 6 latches on invalid or unsupported data.
// - Communication bit 5 latches on packet check failure.
// - Communication bit 4 latches on register write during memory programming.
// - Communication bit 1 latches on any other communication fault.
// - Vendor command returns one byte of vendor flags, default 0x00.
// - Input command returns one byte of input flags, default 0x00.

`include "fsb_defs.svh"

module fsb_bank (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   // ************************************************************
   // Detector levels from the analog side (asynchronous)
   // ************************************************************
   input  wire logic       i_input_overvoltage_fault,
   input  wire logic       i_input_undervoltage_fault,
   input  wire logic       i_input_overcurrent_fault,
   input  wire logic       i_input_overcurrent_warning,
   input  wire logic       i_overtemp_fault,
   input  wire logic       i_overtemp_warning,
   // Vendor flag events, already on this clock
   input  wire logic [7:0] i_vendor_set,
   // ************************************************************
   // Command decoder events, on this clock, one-cycle pulses
   // ************************************************************
   input  wire logic       i_bad_command_received,
   input  wire logic       i_bad_payload_received,
   input  wire logic       i_packet_check_failed,
   input  wire logic       i_reg_write,
   input  wire logic       i_nvm_busy,
   input  wire logic       i_other_comm_fault,
   input  wire logic       i_clear_faults,
   // ************************************************************
   // Read port toward the command decoder
   // ************************************************************
   input  wire logic       i_rd_req,
   input  wire logic [7:0] i_rd_cmd,
   output logic            o_rd_valid,
   output logic            o_rd_hit,
   output logic      [7:0] o_rd_data,
   output logic      [7:0] o_input_flags,
   output logic      [7:0] o_temp_flags,
   output logic      [7:0] o_cml_flags,
   output logic      [7:0] o_vendor_flags
);
   // ************************************************************
   // Synchronised detector levels
   // ************************************************************
   logic [5:0] det_sync;

   fsb_sync #(
      .W (6)
   ) u_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_async ({i_input_overvoltage_fault, i_input_undervoltage_fault,
                 i_input_overcurrent_fault, i_input_overcurrent_warning,
                 i_overtemp_fault, i_overtemp_warning}),
      .o_sync  (det_sync)
   );

   // ************************************************************
   // Set vectors for the input, temperature and communication bytes
   // ************************************************************
   logic [7:0] in_set;
   logic [7:0] tmp_set;
   logic [7:0] cml_set;

   always_comb begin
      in_set = 8'h00;
      in_set[`FSB_IN_OVF_BIT] = det_sync[5];
      in_set[`FSB_IN_UVF_BIT] = det_sync[4];
      in_set[`FSB_IN_OCF_BIT] = det_sync[3];
      in_set[`FSB_IN_OCW_BIT] = det_sync[2];
   end

   always_comb begin
      tmp_set = 8'h00;
      tmp_set[`FSB_TMP_OTF_BIT] = det_sync[1];
      tmp_set[`FSB_TMP_OTW_BIT] = det_sync[0];
   end

   always_comb begin
      cml_set = 8'h00;
      cml_set[`FSB_CML_CMD_BIT]  = i_bad_command_received;
      cml_set[`FSB_CML_DATA_BIT] = i_bad_payload_received;
      cml_set[`FSB_CML_PEC_BIT]  = i_packet_check_failed;
      // Writes during programming are dropped upstream; only flagged here
      cml_set[`FSB_CML_MEM_BIT]  = i_reg_write & i_nvm_busy;
      cml_set[`FSB_CML_COM_BIT]  = i_other_comm_fault;
   end

   // ************************************************************
   // Latched bytes
   // ************************************************************
   logic [7:0] in_flags;
   logic [7:0] tmp_flags;
   logic [7:0] cml_flags;
   logic [7:0] ven_flags;

   fsb_flag_byte #(.MASK (`FSB_IN_MASK)) u_input (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_set   (in_set),
      .i_clear (i_clear_faults),
      .o_flags (in_flags)
   );

   fsb_flag_byte #(.MASK (`FSB_TMP_MASK)) u_temp (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_set   (tmp_set),
      .i_clear (i_clear_faults),
      .o_flags (tmp_flags)
   );

   fsb_flag_byte #(.MASK (`FSB_CML_MASK)) u_cml (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_set   (cml_set),
      .i_clear (i_clear_faults),
      .o_flags (cml_flags)
   );

   fsb_flag_byte #(.MASK (`FSB_VENDOR_MASK)) u_vendor (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_set   (i_vendor_set),
      .i_clear (i_clear_faults),
      .o_flags (ven_flags)
   );

   assign o_input_flags  = in_flags;
   assign o_temp_flags   = tmp_flags;
   assign o_cml_flags    = cml_flags;
   assign o_vendor_flags = ven_flags;

   // ************************************************************
   // Read port: answer one cycle after the request
   // ************************************************************
   typedef struct packed {
      fsb_pkg::fsb_rd_state_t state;
      logic                   hit;
      logic [7:0]             data;
   } fsb_rd_t;

   fsb_rd_t rd_r;
   fsb_rd_t rd_nxt;

   always_comb begin
      rd_nxt = rd_r;
      if (i_ce) begin
         case (rd_r.state)
            fsb_pkg::FSB_RD_IDLE: begin
               if (i_rd_req) begin
                  rd_nxt.state = fsb_pkg::FSB_RD_DONE;
                  rd_nxt.hit   = 1'b1;
                  case (i_rd_cmd)
                     `FSB_CMD_INPUT:  rd_nxt.data = in_flags;
                     `FSB_CMD_TEMP:   rd_nxt.data = tmp_flags;
                     `FSB_CMD_CML:    rd_nxt.data = cml_flags;
                     `FSB_CMD_VENDOR: rd_nxt.data = ven_flags;
                     default: begin
                        // Other codes belong to other blocks of the decoder
                        rd_nxt.hit  = 1'b0;
                        rd_nxt.data = 8'h00;
                     end
                  endcase
               end
            end
            fsb_pkg::FSB_RD_DONE: begin
               // Back to idle; a request here is ignored, not kept
               rd_nxt.state = fsb_pkg::FSB_RD_IDLE;
            end
            default: begin
               rd_nxt.state = fsb_pkg::FSB_RD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_r <= '{state: fsb_pkg::FSB_RD_IDLE, hit: 1'b0, data: `FSB_RESET_BYTE};
      end else begin
         rd_r <= rd_nxt;
      end
   end

   assign o_rd_valid = (rd_r.state == fsb_pkg::FSB_RD_DONE);
   assign o_rd_hit   = rd_r.hit & o_rd_valid;
   assign o_rd_data  = rd_r.data;
endmodule

//--- pkg/fsb_defs.svh
`ifndef FSB_DEFS_SVH
`define FSB_DEFS_SVH

// Command codes of the status bytes
`define FSB_CMD_INPUT      8'h7c
`define FSB_CMD_TEMP       8'h7d
`define FSB_CMD_CML        8'h7e
`define FSB_CMD_VENDOR     8'h80

// Reset value of every status byte
`define FSB_RESET_BYTE     8'h00

// Input byte bit positions
`define FSB_IN_OVF_BIT     7
`define FSB_IN_UVF_BIT     4
`define FSB_IN_OCF_BIT     2
`define FSB_IN_OCW_BIT     1

// Temperature byte bit positions
`define FSB_TMP_OTF_BIT    7
`define FSB_TMP_OTW_BIT    6

// Communication byte bit positions
`define FSB_CML_CMD_BIT    7
`define FSB_CML_DATA_BIT   6
`define FSB_CML_PEC_BIT    5
`define FSB_CML_MEM_BIT    4
`define FSB_CML_COM_BIT    1

// Implemented bits of each byte; all others read zero
`define FSB_IN_MASK        8'h96
`define FSB_TMP_MASK       8'hc0
`define FSB_CML_MASK       8'hf2
`define FSB_VENDOR_MASK    8'hff

`endif

//--- pkg/fsb_pkg.sv
package fsb_pkg;
   typedef enum logic [1:0] {
      FSB_SEL_INPUT  = 2'b00,
      FSB_SEL_TEMP   = 2'b01,
      FSB_SEL_CML    = 2'b10,
      FSB_SEL_VENDOR = 2'b11
   } fsb_sel_t;

   typedef enum logic [1:0] {
      FSB_RD_IDLE = 2'b00,
      FSB_RD_DONE = 2'b01
   } fsb_rd_state_t;
endpackage

//--- verilog/fsb_flag_byte.sv
`include "fsb_defs.svh"

// One latched status byte: sticky set, set wins over clear, masked bits read zero
module fsb_flag_byte #(
   parameter logic [7:0] MASK = 8'hff
) (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   input  wire logic [7:0] i_set,
   input  wire logic       i_clear,
   output logic      [7:0] o_flags
);
   typedef struct packed {
      logic [7:0] flags;
   } fsb_byte_state_t;

   fsb_byte_state_t st_r;
   fsb_byte_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (i_ce) begin
         // Set wins so an event in the clear cycle is kept
         st_nxt.flags = ((i_clear ? 8'h00 : st_r.flags) | i_set) & MASK;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '{flags: `FSB_RESET_BYTE};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_flags = st_r.flags;
endmodule

//--- verilog/fsb_sync.sv
// Two-flop synchroniser for a vector of asynchronous detector levels
module fsb_sync #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fsb_sync_state_t;

   fsb_sync_state_t st_r;
   fsb_sync_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (i_ce) begin
         st_nxt.s1 = i_async;
         st_nxt.s2 = st_r.s1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.s2;
endmodule

//--- verification/fsb_bank_props.sv
`include "fsb_defs.svh"

module fsb_bank_props (
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic       i_ce,
   input wire logic       i_input_overvoltage_fault,
   input wire logic       i_packet_check_failed,
   input wire logic       i_reg_write,
   input wire logic       i_nvm_busy,
   input wire logic       i_clear_faults,
   input wire logic       i_rd_req,
   input wire logic [7:0] i_rd_cmd,
   input wire logic       o_rd_valid,
   input wire logic       o_rd_hit,
   input wire logic [7:0] o_rd_data,
   input wire logic [7:0] o_input_flags,
   input wire logic [7:0] o_temp_flags,
   input wire logic [7:0] o_cml_flags
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // A request during the answer cycle is dropped, so it is not a take
   sequence s_take; i_ce && i_rd_req && !o_rd_valid; endsequence
   sequence s_ovf_held; (i_ce && i_input_overvoltage_fault) [*3]; endsequence
   property p_rd_ans; s_take |=> o_rd_valid; endproperty
   property p_rd_one; o_rd_valid && i_ce |=> !o_rd_valid; endproperty
   property p_rd_temp;
      s_take ##0 (i_rd_cmd == `FSB_CMD_TEMP) |=> o_rd_hit && o_rd_data == $past(o_temp_flags);
   endproperty
   property p_mask;
      ((o_input_flags & ~`FSB_IN_MASK) | (o_temp_flags & ~`FSB_TMP_MASK)
       | (o_cml_flags & ~`FSB_CML_MASK)) == 8'h00;
   endproperty
   property p_pec; i_ce && i_packet_check_failed |=> o_cml_flags[5]; endproperty
   property p_mem; i_ce && i_reg_write && i_nvm_busy |=> o_cml_flags[4]; endproperty
   property p_ovf; s_ovf_held |=> o_input_flags[7]; endproperty
   property p_sticky; o_cml_flags[5] && !(i_ce && i_clear_faults) |=> o_cml_flags[5]; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   a_rd_one: assert property (p_rd_one) else $error("answer longer than one cycle");
   a_rd_temp: assert property (p_rd_temp) else $error("temperature read wrong");
   a_mask: assert property (p_mask) else $error("unsupported bit set");
   a_pec: assert property (p_pec) else $error("packet check flag missed");
   a_mem: assert property (p_mem) else $error("memory error flag missed");
   a_ovf: assert property (p_ovf) else $error("over-voltage flag missed");
   a_sticky: assert property (p_sticky) else $error("flag lost without clear");
endmodule

bind fsb_bank fsb_bank_props chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
   .i_input_overvoltage_fault(i_input_overvoltage_fault),
   .i_packet_check_failed(i_packet_check_failed), .i_reg_write(i_reg_write),
   .i_nvm_busy(i_nvm_busy), .i_clear_faults(i_clear_faults), .i_rd_req(i_rd_req),
   .i_rd_cmd(i_rd_cmd), .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit),
   .o_rd_data(o_rd_data), .o_input_flags(o_input_flags),
   .o_temp_flags(o_temp_flags), .o_cml_flags(o_cml_flags));

//--- verification/fsb_host_model.sv
module fsb_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_rd_valid,
   input  wire logic       i_rd_hit,
   input  wire logic [7:0] i_rd_data,
   output logic            o_rd_req,
   output logic      [7:0] o_rd_cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_rd_req = 1'b0;
      o_rd_cmd = 8'h00;
   end
   // Idle code line shows the inverse of the last code; after a 0x7f read that is the vendor code 0x80
   task automatic read(input logic [7:0] c, output logic [7:0] d, output logic h);
      @(posedge i_clk);
      #10 o_rd_req = 1'b1;
      o_rd_cmd = c;
      @(posedge i_clk);
      #10 d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
      h = i_rd_hit & (i_rd_valid === 1'b1);
      // Held over the edge after the answer is sampled; the design ignores it there
      @(posedge i_clk);
      #10 o_rd_req = 1'b0;
      o_rd_cmd = ~c;
   endtask
endmodule

//--- verification/test_fsb_bank.sv
`include "fsb_defs.svh"

module test_fsb_bank;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, nrst, ce, clr, req, vld, hit;
   logic [5:0] det, cm;
   logic [7:0] vset, cmd, rdat, fin, ftm, fcm, fvn;
   logic [7:0] e_in, e_tm, e_cm, e_vn;
   int         num_errors = 0;
   int         n_compared = 0;
   integer     seed = 11;
   int         rnd;

   fsb_bank dut_u (.i_clk(clk), .i_nrst(nrst), .i_ce(ce),
      .i_input_overvoltage_fault(det[5]), .i_input_undervoltage_fault(det[4]),
      .i_input_overcurrent_fault(det[3]), .i_input_overcurrent_warning(det[2]),
      .i_overtemp_fault(det[1]), .i_overtemp_warning(det[0]), .i_vendor_set(vset),
      .i_bad_command_received(cm[5]), .i_bad_payload_received(cm[4]),
      .i_packet_check_failed(cm[3]), .i_reg_write(cm[2]), .i_nvm_busy(cm[1]),
      .i_other_comm_fault(cm[0]), .i_clear_faults(clr), .i_rd_req(req), .i_rd_cmd(cmd),
      .o_rd_valid(vld), .o_rd_hit(hit), .o_rd_data(rdat), .o_input_flags(fin),
      .o_temp_flags(ftm), .o_cml_flags(fcm), .o_vendor_flags(fvn));
   fsb_host_model host_u (.i_clk(clk), .i_rd_valid(vld), .i_rd_hit(hit),
      .i_rd_data(rdat), .o_rd_req(req), .o_rd_cmd(cmd));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [7:0] f_in(input logic [5:0] d);
      return {d[5], 2'b00, d[4], 1'b0, d[3], d[2], 1'b0};
   endfunction
   function automatic logic [7:0] f_cm(input logic [5:0] c);
      return {c[5], c[4], c[3], c[2] & c[1], 2'b00, c[0], 1'b0};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] c, input logic [7:0] exp, input logic h);
      logic [7:0] d;
      logic       g;
      host_u.read(c, d, g);
      chk(d, exp);
      chk({7'h00, g}, {7'h00, h});
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #1000000;
      num_errors++;
      finish_test();
   end

   initial begin
      ce = 1'b1;
      nrst = 1'b0; clr = 1'b0; det = '0; cm = '0; vset = '0;
      e_in = '0; e_tm = '0; e_cm = '0; e_vn = '0;
      repeat (12) @(posedge clk);
      #10 nrst = 1'b1;
      rdc(`FSB_CMD_INPUT, 8'h00, 1'b1);
      rdc(`FSB_CMD_TEMP, 8'h00, 1'b1);
      rdc(`FSB_CMD_CML, 8'h00, 1'b1);
      rdc(`FSB_CMD_VENDOR, 8'h00, 1'b1);
      rdc(8'h7f, 8'h00, 1'b0);
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         #10 rnd = $random(seed);
         cm = rnd[5:0];
         vset = rnd[13:6];
         det = rnd[19:14];
         clr = i[0];
         // Corner: every communication and detector source at once, together with a clear that must lose
         if (i == 1) begin
            cm = '1;
            det = '1;
         end
         e_in = (clr ? 8'h00 : e_in) | f_in(det);
         e_tm = (clr ? 8'h00 : e_tm) | {det[1:0], 6'h00};
         e_cm = (clr ? 8'h00 : e_cm) | f_cm(cm);
         e_vn = (clr ? 8'h00 : e_vn) | vset;
         @(posedge clk);
         #10 cm = '0;
         vset = '0;
         clr = 1'b0;
         repeat (3) @(posedge clk);
         #10 det = '0;
         rdc(`FSB_CMD_INPUT, e_in, 1'b1);
         rdc(`FSB_CMD_TEMP, e_tm, 1'b1);
         rdc(`FSB_CMD_CML, e_cm, 1'b1);
         rdc(`FSB_CMD_VENDOR, e_vn, 1'b1);
         chk(fcm, e_cm);
         chk(fin, e_in);
         chk(ftm, e_tm);
         chk(fvn, e_vn);
      end
      // Clock enable low: pulses and clear are lost, every byte stays put
      @(posedge clk);
      #10 ce = 1'b0;
      cm = '1;
      vset = '1;
      clr = 1'b1;
      @(posedge clk);
      #10 ce = 1'b1;
      cm = '0;
      vset = '0;
      clr = 1'b0;
      chk(fcm, e_cm);
      chk(fvn, e_vn);
      chk(fin, e_in);
      // Reset in mid-run drops every latched flag
      @(posedge clk);
      #10 nrst = 1'b0;
      repeat (2) @(posedge clk);
      #10 nrst = 1'b1;
      chk(fin, 8'h00);
      chk(ftm, 8'h00);
      chk(fcm, 8'h00);
      chk(fvn, 8'h00);
      rdc(`FSB_CMD_CML, 8'h00, 1'b1);
      rdc(`FSB_CMD_VENDOR, 8'h00, 1'b1);
      finish_test();
   end
endmodule
